// ---- logic/eeprom_addr_defines.vh ----
/*
 * constants for the serial memory address decode / write protect block.
 * assumes inclusion by bare name from the design file.
 */
`ifndef EEPROM_ADDR_DEFINES_VH
`define EEPROM_ADDR_DEFINES_VH
// ---------------------------------------------------------------------
// apb register map
// ---------------------------------------------------------------------
`define REG_CTRL          12'h000
`define REG_STATUS        12'h004
`define REG_ADDR          12'h008
`define REG_WDATA         12'h00c
// ctrl fields
`define CTRL_NV_DONE_BIT  0
// status fields
`define ST_ACTIVE_BIT     0
`define ST_BUSY_BIT       1
`define ST_RW_BIT         2
`define ST_PROT_BIT       3
`define ST_MISS_BIT       4
// ---------------------------------------------------------------------
// slave byte layout
// ---------------------------------------------------------------------
// device type code: arbitrary value, does not name any real part
`define TYPE_CODE         4'h5
`define MSB_HALF_BIT      8
// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define CLK_MHZ           250
`define STBY_DELAY_NS     200
`define STBY_DELAY_CYC    ((`STBY_DELAY_NS * `CLK_MHZ) / 1000)
`define NV_WRITE_CYCLE_US 5000
`define NV_WRITE_CYCLE_CYC (`NV_WRITE_CYCLE_US * `CLK_MHZ)
`define MISMATCH_CLOCKS   9
`endif

// ---- logic/eeprom_addr_decode.v ----
/*
 * two-wire slave address decode, word address sourcing, upper half write
 * protection and active/standby control, with an apb status/control view.
 * assumes scl/sda arrive asynchronously and are synchronised here; the
 * external bus resolves sda from the open-drain enable.
 * limitations: read data is never shifted out, page writes are not
 * sequenced and the address counter does not advance after a transfer;
 * the array itself lives outside this block and takes word_addr_o and
 * nv_write_start_o. the straps are expected to stay still while the
 * bus is busy, so they pass the same two flops as the bus lines and no
 * glitch filter. the ack lags scl fall by about three clocks, which the
 * bus low time covers many times over at any legal scl rate.
 * a protected write is refused on its data byte: the slave byte and the
 * word address are still acknowledged, and the address is loaded.
 * all status flags reset to zero.
 */
`timescale 1ns/1ps
`include "eeprom_addr_defines.vh"

module eeprom_addr_decode #(
    parameter NV_WRITE_CYC = `NV_WRITE_CYCLE_CYC
) (
    input  wire        clk_i,
    input  wire        resetn_i,
    input  wire        scl_i,
    input  wire        sda_i,
    input  wire        select_one_pin_i,
    input  wire        select_two_pin_i,
    input  wire        protect_pin_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    output reg         sda_o,
    output reg         sda_oe_n_o,
    output reg         active_o,
    output reg  [8:0]  word_addr_o,
    output reg         rw_o,
    output reg         nv_write_start_o
);
    localparam STBY_CYC = (`STBY_DELAY_CYC < 1) ? 1 : `STBY_DELAY_CYC;
    // ninth scl rise after a start ends a mismatched slave byte
    localparam integer MISS_CLKS = `MISMATCH_CLOCKS;

    // S_MISS also covers busy and protected refusals: all stay silent
    localparam S_IDLE  = 3'h0;
    localparam S_SLAVE = 3'h1;
    localparam S_SACK  = 3'h2;
    localparam S_WADDR = 3'h3;
    localparam S_WACK  = 3'h4;
    localparam S_DATA  = 3'h5;
    localparam S_DACK  = 3'h6;
    localparam S_MISS  = 3'h7;

    // -----------------------------------------------------------------
    // input synchronisers
    // -----------------------------------------------------------------
    // protect resets low so the first clocks after reset never block writes
    reg [1:0] scl_s;
    reg [1:0] sda_s;
    reg [1:0] s1_s;
    reg [1:0] s2_s;
    reg [1:0] wp_s;
    reg       scl_d;
    reg       sda_d;
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            s1_s  <= 2'h0;
            s2_s  <= 2'h0;
            wp_s  <= 2'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], scl_i};
            sda_s <= {sda_s[0], sda_i};
            s1_s  <= {s1_s[0], select_one_pin_i};
            s2_s  <= {s2_s[0], select_two_pin_i};
            wp_s  <= {wp_s[0], protect_pin_i};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
        end
    end
    wire scl    = scl_s[1];
    wire sda    = sda_s[1];
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    // start and stop compare delayed copies, so sda and scl share one latency
    wire start_det = scl & scl_d & sda_d & ~sda;
    wire stop_det  = scl & scl_d & ~sda_d & sda;

    // -----------------------------------------------------------------
    // protocol state
    // -----------------------------------------------------------------
    reg [2:0]  state;
    reg [3:0]  bitcnt;
    reg [7:0]  shift;
    reg        addr_msb;
    reg [8:0]  addr_cnt;
    reg        nv_busy;
    reg [31:0] nv_cnt;
    reg        data_seen;
    reg        stby_pend;
    reg [7:0]  stby_cnt;
    reg        miss_flag;
    reg        prot_flag;
    reg        sw_done;
    reg [7:0]  wdata_last;
    reg [3:0]  start_clks;

    wire [7:0] next_shift = {shift[6:0], sda};
    // only bits 7 to 2 of the complete byte are compared
    wire       type_ok    = (next_shift[7:4] == `TYPE_CODE);
    wire       select_ok  = (next_shift[3] == s2_s[1]) && (next_shift[2] == s1_s[1]);
    wire       sel_match  = type_ok && select_ok;
    // upper half locked while protect is high
    // addr_msb alone marks the upper half, so no compare is needed
    wire       wr_blocked = wp_s[1] & addr_msb;
    // a stop launches a write only after a full data byte and its ack
    wire       write_stop = (state != S_IDLE) && (state != S_MISS) && !rw_o && data_seen && !nv_busy;

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            state            <= S_IDLE;
            bitcnt           <= 4'h0;
            shift            <= 8'h00;
            addr_msb         <= 1'b0;
            addr_cnt         <= 9'h000;
            nv_busy          <= 1'b0;
            nv_cnt           <= 32'h0;
            data_seen        <= 1'b0;
            stby_pend        <= 1'b0;
            stby_cnt         <= 8'h00;
            miss_flag        <= 1'b0;
            prot_flag        <= 1'b0;
            sda_o            <= 1'b1;
            sda_oe_n_o       <= 1'b1;
            active_o         <= 1'b0;
            word_addr_o      <= 9'h000;
            rw_o             <= 1'b0;
            nv_write_start_o <= 1'b0;
            wdata_last       <= 8'h00;
            start_clks       <= 4'h0;
        end else begin
            nv_write_start_o <= 1'b0;
            sda_o            <= 1'b0;
            // scl rises since the last start, saturating
            if (start_det) begin
                start_clks <= 4'h0;
            end else if (scl_rise && start_clks != 4'hf) begin
                start_clks <= start_clks + 4'h1;
            end
            // software may cut the write cycle short through the control register
            // standby only when the write cycle finishes
            if (nv_busy) begin
                if (nv_cnt >= NV_WRITE_CYC - 1 || sw_done) begin
                    nv_busy  <= 1'b0;
                    active_o <= 1'b0;
                end else begin
                    nv_cnt <= nv_cnt + 32'h1;
                end
            end
            // fixed delay after a stop without write
            // a fresh start below cancels a pending standby
            if (stby_pend) begin
                if (stby_cnt >= STBY_CYC - 1) begin
                    stby_pend <= 1'b0;
                    if (!nv_busy) begin
                        active_o <= 1'b0;
                    end
                end else begin
                    stby_cnt <= stby_cnt + 8'h01;
                end
            end
            if (start_det) begin
                active_o   <= 1'b1;
                stby_pend  <= 1'b0;
                state      <= S_SLAVE;
                bitcnt     <= 4'h0;
                sda_oe_n_o <= 1'b1;
                miss_flag  <= 1'b0;
            end else if (stop_det) begin
                sda_oe_n_o <= 1'b1;
                if (write_stop) begin
                    nv_busy          <= 1'b1;
                    nv_cnt           <= 32'h0;
                    nv_write_start_o <= 1'b1;
                end else if (!nv_busy) begin
                    stby_pend <= 1'b1;
                    stby_cnt  <= 8'h00;
                end
                data_seen <= 1'b0;
                state     <= S_IDLE;
            end else begin
                case (state)
                    S_SLAVE: begin
                        if (scl_rise) begin
                            shift  <= next_shift;
                            bitcnt <= bitcnt + 4'h1;
                            if (bitcnt == 4'h7) begin
                                // rw_o keeps the last slave byte's lsb until the next one
                                addr_msb <= next_shift[1];
                                rw_o     <= next_shift[0];
                                if (sel_match && !nv_busy) begin
                                    state <= S_SACK;
                                    // counter keeps its reset value until first loaded
                                    if (next_shift[0]) begin
                                        word_addr_o <= addr_cnt;
                                    end
                                end else begin
                                    state     <= S_MISS;
                                    miss_flag <= ~sel_match;
                                    bitcnt    <= 4'h0;
                                end
                            end
                        end
                    end
                    S_SACK, S_WACK, S_DACK: begin
                        // ack driven over the ninth clock
                        if (scl_fall && sda_oe_n_o) begin
                            sda_oe_n_o <= 1'b0;
                        end else if (scl_fall && !sda_oe_n_o) begin
                            // released on the next fall, so the ack holds over the whole high phase
                            sda_oe_n_o <= 1'b1;
                            bitcnt     <= 4'h0;
                            if (state == S_DACK) begin
                                data_seen <= 1'b1;
                            end
                            if (state == S_SACK && !rw_o) begin
                                state <= S_WADDR;
                            end else if (state == S_SACK) begin
                                state <= S_IDLE;
                            end else begin
                                state <= S_DATA;
                            end
                        end
                    end
                    S_WADDR: begin
                        if (scl_rise) begin
                            shift  <= next_shift;
                            bitcnt <= bitcnt + 4'h1;
                            if (bitcnt == 4'h7) begin
                                word_addr_o <= {addr_msb, next_shift};
                                addr_cnt    <= {addr_msb, next_shift};
                                state       <= S_WACK;
                                bitcnt      <= 4'h0;
                            end
                        end
                    end
                    S_DATA: begin
                        if (scl_rise) begin
                            shift  <= next_shift;
                            bitcnt <= bitcnt + 4'h1;
                            if (bitcnt == 4'h7) begin
                                bitcnt <= 4'h0;
                                // the data byte is shifted in in full before it is refused
                                // protected write abandoned
                                if (wr_blocked) begin
                                    prot_flag <= 1'b1;
                                    data_seen <= 1'b0;
                                    state     <= S_MISS;
                                end else begin
                                    wdata_last <= next_shift;
                                    state      <= S_DACK;
                                end
                            end
                        end
                    end
                    S_MISS: begin
                        sda_oe_n_o <= 1'b1;
                        // the ninth rise after the start ends the mismatched byte
                        if (scl_rise && !nv_busy && miss_flag && start_clks == MISS_CLKS - 1) begin
                            active_o <= 1'b0;
                        end
                    end
                    default: begin
                        sda_oe_n_o <= 1'b1;
                    end
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // apb slave, zero wait state
    // -----------------------------------------------------------------
    // status reads are a snapshot taken in the setup cycle
    wire apb_acc = psel_i & penable_i;
    wire known   = (paddr_i == `REG_CTRL) || (paddr_i == `REG_STATUS) ||
                   (paddr_i == `REG_ADDR) || (paddr_i == `REG_WDATA);
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            prdata_o  <= 32'h0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            sw_done   <= 1'b0;
        end else begin
            // pready rises with penable and drops straight after
            pready_o  <= psel_i & ~pready_o;
            pslverr_o <= psel_i & ~pready_o & ~known;
            // early end of the write cycle, one pulse
            sw_done   <= apb_acc & pready_o & pwrite_i & (paddr_i == `REG_CTRL) &
                         pwdata_i[`CTRL_NV_DONE_BIT];
            case (paddr_i)
                `REG_STATUS: prdata_o <= {27'h0, miss_flag, prot_flag, rw_o, nv_busy, active_o};
                `REG_ADDR:   prdata_o <= {23'h0, word_addr_o};
                `REG_WDATA:  prdata_o <= {24'h0, wdata_last};
                default:     prdata_o <= 32'h0;
            endcase
        end
    end
endmodule

// ---- tb/eeprom_addr_decode_sva.sv ----
/* concurrent checks on the address decode block ports.
   assumes binding onto eeprom_addr_decode, one clock, sync reset. */
`timescale 1ns/1ps
module eeprom_addr_decode_sva #(
    parameter NV_WRITE_CYC = 200
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic active_o,
    input wire logic nv_write_start_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // margin of a few clocks: the busy count may end a clock early
    logic [31:0] busy_cnt;
    always @(posedge clk_i) begin
        if (!resetn_i) busy_cnt <= 0;
        else if (nv_write_start_o) busy_cnt <= 1;
        else if (busy_cnt != 0 && busy_cnt < NV_WRITE_CYC - 4) busy_cnt <= busy_cnt + 1;
        else busy_cnt <= 0;
    end
    sequence setup_s; psel_i && !penable_i; endsequence
    sequence access_s; psel_i && penable_i; endsequence
    apb_answer_a: assert property (setup_s ##1 access_s |-> pready_o)
        else $error("apb access not answered");
    pready_pulse_a: assert property (pready_o |=> !pready_o) else $error("pready held");
    slverr_gate_a: assert property (pslverr_o |-> pready_o) else $error("pslverr without pready");
    ack_drive_a: assert property (!sda_oe_n_o |-> !sda_o && active_o)
        else $error("ack drive wrong");
    ack_window_a: assert property ($changed(sda_oe_n_o) |-> !scl_i)
        else $error("sda changed while scl high");
    nv_pulse_a: assert property (nv_write_start_o |=> !nv_write_start_o)
        else $error("write start not a pulse");
    nv_busy_a: assert property (busy_cnt != 0 |-> active_o && sda_oe_n_o)
        else $error("standby or ack during write cycle");
    start_active_a: assert property (scl_i && $fell(sda_i) |-> ##[1:8] active_o)
        else $error("start did not wake device");
endmodule

bind eeprom_addr_decode eeprom_addr_decode_sva #(.NV_WRITE_CYC(NV_WRITE_CYC)) eeprom_addr_decode_sva_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl_i), .sda_i(sda_i), .psel_i(psel_i),
    .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .active_o(active_o), .nv_write_start_o(nv_write_start_o));

// ---- tb/twowire_master.sv ----
/* two-wire bus master model, 8 clocks per bit (32 ns link clock).
   assumes sda_i is the resolved wire with pull-up; high here releases. */
`timescale 1ns/1ps
module twowire_master (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task tick(input int n); repeat (n) @(posedge clk_i); endtask
    task start;
        tick(1); sda_o <= 1'b1; tick(3); scl_o <= 1'b1; tick(4); sda_o <= 1'b0; tick(4); scl_o <= 1'b0;
    endtask
    task stop;
        tick(1); sda_o <= 1'b0; tick(3); scl_o <= 1'b1; tick(4); sda_o <= 1'b1; tick(4);
    endtask
    // data moves one clock after scl falls so the synced lines never race
    task put_bit(input logic b, output logic s);
        tick(1); sda_o <= b; tick(3); scl_o <= 1'b1; tick(4); s = sda_i; scl_o <= 1'b0;
    endtask
    task send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(b[i], s);
        put_bit(1'b1, s);
        ack = !s;
    endtask
endmodule

// ---- tb/eeprom_addr_decode_test.sv ----
/* random and corner traffic for the address decode block.
   assumes the master model, the checker bind and the design defines. */
`timescale 1ns/1ps
`include "eeprom_addr_defines.vh"
module eeprom_addr_decode_test;
    logic        clk_i = 0, resetn_i = 0, sel1 = 0, sel2 = 0, prot = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic        pready, pslverr, sda_o, sda_oe_n_o, active_o, rw_o, nv_start, scl, m_sda, ack, e;
    logic [8:0]  word_addr;
    wire         sda_bus = m_sda & (sda_oe_n_o | sda_o);
    int          failures = 0, checks = 0, seed = 34611, nv_cnt = 0;
    twowire_master twowire_master_inst (.clk_i(clk_i), .sda_i(sda_bus), .scl_o(scl), .sda_o(m_sda));
    eeprom_addr_decode #(.NV_WRITE_CYC(200)) eeprom_addr_decode_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_bus), .select_one_pin_i(sel1),
        .select_two_pin_i(sel2), .protect_pin_i(prot), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .active_o(active_o),
        .word_addr_o(word_addr), .rw_o(rw_o), .nv_write_start_o(nv_start));
    initial forever #2 clk_i = ~clk_i;
    always @(posedge clk_i) if (nv_start === 1'b1) nv_cnt++;
    task summarize;
        if (failures == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
        int n;
        @(posedge clk_i); psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_i); penable <= 1;
        n = 0;
        do begin @(posedge clk_i); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [31:0] x;
        logic [3:0]  ty;
        logic [1:0]  ss;
        logic        pr, a8, rw, match, ok, have_wa;
        logic [8:0]  last_wa;
        int          n0;
        have_wa = 0;
        last_wa = 0;
        repeat (12) @(posedge clk_i); resetn_i <= 1; repeat (4) @(posedge clk_i);
        apb(1'b0, 12'h010, 32'h0, r, e);
        chk("unmapped err", 1, e);
        chk("unmapped data", 0, r);
        for (int i = 0; i < 24; i++) begin
            x = $random(seed);
            pr = x[2]; a8 = x[3]; rw = (x[21:20] == 0);
            ty = (x[23:22] == 0) ? (`TYPE_CODE ^ 4'h3) : `TYPE_CODE;
            ss = (x[25:24] == 0) ? {~x[1], x[0]} : x[1:0];
            // corners: protected upper write, open upper write, protected lower boundary
            if (i < 3) begin ty = `TYPE_CODE; ss = x[1:0]; rw = 0; pr = (i != 1); a8 = (i != 2); end
            if (i == 2) x[11:4] = 8'hff;
            sel1 <= x[0]; sel2 <= x[1]; prot <= pr;
            match = (ty == `TYPE_CODE) && (ss == x[1:0]);
            ok = !(a8 && pr);
            repeat (4) @(posedge clk_i);
            twowire_master_inst.start();
            twowire_master_inst.send_byte({ty, ss, a8, rw}, ack);
            chk("slave ack", match, ack);
            if (!match) begin
                twowire_master_inst.send_byte(8'h00, ack);
                chk("ignored ack", 0, ack);
                chk("mismatch standby", 0, active_o);
                twowire_master_inst.stop();
                apb(1'b0, `REG_STATUS, 32'h0, r, e);
                chk("miss flag", 1, r[`ST_MISS_BIT]);
            end else if (rw) begin
                chk("read dir", 1, rw_o);
                if (have_wa) chk("read addr", last_wa, word_addr);
                twowire_master_inst.stop();
                repeat (60) @(posedge clk_i);
                chk("read standby", 0, active_o);
            end else begin
                if (ack) begin
                    last_wa = {a8, x[11:4]};
                    have_wa = 1;
                end
                if (ack) twowire_master_inst.send_byte(x[11:4], ack);
                if (ack) twowire_master_inst.send_byte(x[19:12], ack);
                chk("write ack", ok, ack);
                n0 = nv_cnt;
                twowire_master_inst.stop();
                repeat (8) @(posedge clk_i);
                chk("nv start", ok, 32'(nv_cnt - n0));
                if (ok) begin
                    chk("word addr", {a8, x[11:4]}, word_addr);
                    chk("write dir", 0, rw_o);
                    apb(1'b0, `REG_ADDR, 32'h0, r, e);
                    chk("addr reg", {a8, x[11:4]}, r);
                    apb(1'b0, `REG_WDATA, 32'h0, r, e);
                    chk("data reg", {24'h0, x[19:12]}, r);
                    twowire_master_inst.start();
                    twowire_master_inst.send_byte({`TYPE_CODE, ss, a8, 1'b0}, ack);
                    chk("poll ack", 0, ack);
                    twowire_master_inst.stop();
                    repeat (200) @(posedge clk_i);
                end else begin
                    apb(1'b0, `REG_STATUS, 32'h0, r, e);
                    chk("prot flag", 1, r[`ST_PROT_BIT]);
                    repeat (60) @(posedge clk_i);
                end
                chk("write standby", 0, active_o);
            end
        end
        summarize;
    end
    initial begin
        repeat (60000) @(posedge clk_i);
        failures++;
        summarize;
    end
endmodule
